// ===== dcbnd_top.sv
// Channel binding, power-down derivation and oscillator divisor bank
`timescale 1ns/1ps
`default_nettype none
module dcbnd_top
  import dcbnd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire dcbnd_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  // Converter core power-down
  input wire logic core_a_powerdown,
  input wire logic core_b_powerdown,
  // Converter core samples
  input wire dcbnd_sample_t core_a_in,
  input wire dcbnd_sample_t core_b_in,
  // Digital channel samples
  output dcbnd_sample_t chan_a_out,
  output dcbnd_sample_t chan_b_out,
  // Derived power-down
  output logic chan_a_powerdown,
  output logic chan_b_powerdown,
  output logic link_a_powerdown,
  output logic link_b_powerdown,
  // Active preset frequency words
  input wire logic [PHASE_W-1:0] freq_word_a,
  input wire logic [PHASE_W-1:0] freq_word_b,
  // Phase synchronisation references
  input wire logic sysref,
  input wire logic sync_request,
  input wire logic multiframe_boundary,
  // Oscillator phases
  output logic [PHASE_W-1:0] chan_a_phase,
  output logic [PHASE_W-1:0] chan_b_phase
);

  function automatic logic hit(input dcbnd_req_t r,
                               input logic [ADDR_W-1:0] a);
    hit = (r.addr == a);
  endfunction

  dcbnd_top_state_t s_q;
  dcbnd_top_state_t s_d;
  logic phase_init;
  logic sync_write;
  logic [PHASE_W-1:0] phase_w [2];
  logic [PHASE_W-1:0] fw_w [2];
  logic adv_w [2];
  logic src_a;
  logic src_b;
  logic pd_a_next;
  logic pd_b_next;

  assign src_a = s_q.binding[BIND_A_BIT];
  assign src_b = s_q.binding[BIND_B_BIT];

  // Routing acts on the live binding; glitch-free changes rely on
  // software having stopped the link and calibration first
  assign pd_a_next = (src_a == SRC_CORE_B) ? core_b_powerdown
                                            : core_a_powerdown;
  assign pd_b_next = (src_b == SRC_CORE_B) ? core_b_powerdown
                                            : core_a_powerdown;

  always_comb begin
    s_d = s_q;
    // Whole bytes stored, reserved bits included
    if (reg_req.wr && hit(reg_req, ADDR_BINDING)) begin
      s_d.binding = reg_req.wdata[7:0];
    end
    if (reg_req.wr && hit(reg_req, ADDR_RDIV)) begin
      s_d.rdiv = reg_req.wdata;
    end
    if (reg_req.wr && hit(reg_req, ADDR_SYNC)) begin
      s_d.sync = reg_req.wdata[7:0];
    end
    s_d.rdata = RDATA_RST;
    if (reg_req.rd) begin
      if (hit(reg_req, ADDR_BINDING)) begin
        s_d.rdata = {8'h00, s_q.binding};
      end else if (hit(reg_req, ADDR_RDIV)) begin
        s_d.rdata = s_q.rdiv;
      end else if (hit(reg_req, ADDR_SYNC)) begin
        s_d.rdata = {8'h00, s_q.sync};
      end
    end
    s_d.pd_a = pd_a_next;
    s_d.pd_b = pd_b_next;
    // Sample routing; a powered-down channel still routes data but drops valid
    s_d.chan_a.data = (src_a == SRC_CORE_B) ? core_b_in.data
                                            : core_a_in.data;
    s_d.chan_a.valid = ((src_a == SRC_CORE_B) ? core_b_in.valid
                                              : core_a_in.valid)
                       & ~pd_a_next;
    s_d.chan_b.data = (src_b == SRC_CORE_B) ? core_b_in.data
                                            : core_a_in.data;
    s_d.chan_b.valid = ((src_b == SRC_CORE_B) ? core_b_in.valid
                                              : core_a_in.valid)
                       & ~pd_b_next;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '{binding: BINDING_RST, rdiv: RDIV_RST, sync: SYNC_RST,
               rdata: RDATA_RST,
               chan_a: '{valid: 1'b0, data: SAMPLE_RST},
               chan_b: '{valid: 1'b0, data: SAMPLE_RST},
               pd_a: 1'b0, pd_b: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_write = reg_req.wr && hit(reg_req, ADDR_SYNC);

  dcbnd_sync_ctrl u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .arm_write(sync_write),
    .arm_value(reg_req.wdata[SYNC_ARM_BIT]),
    .hs_enable(s_q.sync[SYNC_HS_BIT]),
    .sysref(sysref),
    .sync_request(sync_request),
    .boundary(multiframe_boundary),
    .phase_init(phase_init)
  );

  assign fw_w[0] = freq_word_a;
  assign fw_w[1] = freq_word_b;
  assign adv_w[0] = s_q.chan_a.valid;
  assign adv_w[1] = s_q.chan_b.valid;

  // Both channels, whatever preset is active, see the same divisor
  for (genvar i = 0; i < 2; i++) begin : g_osc
    dcbnd_oscillator u_osc (
      .sys_clk(sys_clk),
      .reset(reset),
      .advance(adv_w[i]),
      .init(phase_init),
      .freq_word(fw_w[i]),
      .ref_div(s_q.rdiv),
      .phase(phase_w[i])
    );
  end

  assign reg_rdata = s_q.rdata;
  assign chan_a_out = s_q.chan_a;
  assign chan_b_out = s_q.chan_b;
  assign chan_a_powerdown = s_q.pd_a;
  assign chan_b_powerdown = s_q.pd_b;
  assign link_a_powerdown = s_q.pd_a;
  assign link_b_powerdown = s_q.pd_b;
  assign chan_a_phase = phase_w[0];
  assign chan_b_phase = phase_w[1];

endmodule
`default_nettype wire

// ===== dcbnd_pkg.sv
// Shared constants and types for channel binding and divisor logic
package dcbnd_pkg;

  // Widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned PHASE_W = 32;
  localparam int unsigned RDIV_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_BINDING = 12'h216;
  localparam logic [ADDR_W-1:0] ADDR_RDIV = 12'h217;
  localparam logic [ADDR_W-1:0] ADDR_SYNC = 12'h219;

  // Reset values
  localparam logic [7:0] BINDING_RST = 8'h02;
  localparam logic [RDIV_W-1:0] RDIV_RST = 16'h0000;
  localparam logic [7:0] SYNC_RST = 8'h02;
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  localparam logic [PHASE_W-1:0] PHASE_RST = 32'h00000000;
  localparam logic [RDIV_W-1:0] FRAC_RST = 16'h0000;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 12'h000;

  // Field positions
  localparam int unsigned BIND_A_BIT = 0;
  localparam int unsigned BIND_B_BIT = 1;
  localparam int unsigned SYNC_ARM_BIT = 0;
  localparam int unsigned SYNC_HS_BIT = 1;

  // Binding encodings
  localparam logic SRC_CORE_A = 1'b0;
  localparam logic SRC_CORE_B = 1'b1;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dcbnd_req_t;

  // One sample with its qualifier
  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } dcbnd_sample_t;

  // Handshake-driven phase init sequencer
  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_WAIT = 2'b10
  } dcbnd_hs_t;

  typedef struct packed {
    logic sysref_prev;
    logic req_prev;
    logic arm_last;
    logic armed;
    dcbnd_hs_t hs;
    logic init;
  } dcbnd_sync_state_t;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic [RDIV_W-1:0] frac;
  } dcbnd_osc_state_t;

  typedef struct packed {
    logic [7:0] binding;
    logic [RDIV_W-1:0] rdiv;
    logic [7:0] sync;
    logic [DATA_W-1:0] rdata;
    dcbnd_sample_t chan_a;
    dcbnd_sample_t chan_b;
    logic pd_a;
    logic pd_b;
  } dcbnd_top_state_t;

endpackage

// ===== dcbnd_oscillator.sv
// Phase accumulator with optional reference divisor correction
`timescale 1ns/1ps
`default_nettype none
module dcbnd_oscillator
  import dcbnd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control
  input wire logic advance,
  input wire logic init,
  input wire logic [PHASE_W-1:0] freq_word,
  input wire logic [RDIV_W-1:0] ref_div,
  // Result
  output logic [PHASE_W-1:0] phase
);

  dcbnd_osc_state_t s_q;
  dcbnd_osc_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (init) begin
      s_d.phase = PHASE_RST;
      s_d.frac = FRAC_RST;
    end else if (advance) begin
      if (ref_div == RDIV_RST) begin
        // Plain 32-bit accumulation
        s_d.phase = s_q.phase + freq_word;
        s_d.frac = FRAC_RST;
      end else if (s_q.frac >= ref_div - 16'h0001) begin
        // One extra LSB every ref_div steps removes the step error
        s_d.phase = s_q.phase + freq_word + 32'h00000001;
        s_d.frac = FRAC_RST;
      end else begin
        s_d.phase = s_q.phase + freq_word;
        s_d.frac = s_q.frac + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '{phase: PHASE_RST, frac: FRAC_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.phase;

endmodule
`default_nettype wire

// ===== dcbnd_sync_ctrl.sv
// Oscillator phase initialisation sequencing
`timescale 1ns/1ps
`default_nettype none
module dcbnd_sync_ctrl
  import dcbnd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Software side
  input wire logic arm_write,
  input wire logic arm_value,
  input wire logic hs_enable,
  // Timing references
  input wire logic sysref,
  input wire logic sync_request,
  input wire logic boundary,
  // Result
  output logic phase_init
);

  dcbnd_sync_state_t s_q;
  dcbnd_sync_state_t s_d;
  logic sysref_rise;
  logic req_rise;

  assign sysref_rise = sysref & ~s_q.sysref_prev;
  assign req_rise = sync_request & ~s_q.req_prev;

  always_comb begin
    s_d = s_q;
    s_d.sysref_prev = sysref;
    s_d.req_prev = sync_request;
    s_d.init = 1'b0;
    // Fire once, then stay quiet until armed again
    if (s_q.armed && sysref_rise) begin
      s_d.init = 1'b1;
      s_d.armed = 1'b0;
    end
    // A fresh arm in the firing cycle wins over the disarm
    if (arm_write) begin
      s_d.arm_last = arm_value;
      if (arm_value && !s_q.arm_last) begin
        s_d.armed = 1'b1;
      end else if (!arm_value) begin
        s_d.armed = 1'b0;
      end
    end
    case (s_q.hs)
      HS_IDLE: begin
        if (hs_enable && req_rise) begin
          s_d.hs = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (!hs_enable) begin
          s_d.hs = HS_IDLE;
        end else if (boundary) begin
          s_d.init = 1'b1;
          s_d.hs = HS_IDLE;
        end
      end
      default: begin
        s_d.hs = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q <= '{sysref_prev: 1'b0, req_prev: 1'b0, arm_last: 1'b0,
               armed: 1'b0, hs: HS_IDLE, init: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign phase_init = s_q.init;

endmodule
`default_nettype wire

// ===== dcbnd_props.sv
// Assertions on routing, power-down and register reads
`timescale 1ns/1ps
`default_nettype none
module dcbnd_props
  import dcbnd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire dcbnd_req_t reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Core side
  input wire logic core_a_powerdown,
  input wire logic core_b_powerdown,
  input wire dcbnd_sample_t core_a_in,
  input wire dcbnd_sample_t core_b_in,
  // Channel side
  input wire dcbnd_sample_t chan_a_out,
  input wire dcbnd_sample_t chan_b_out,
  input wire logic chan_a_powerdown,
  input wire logic chan_b_powerdown,
  input wire logic link_a_powerdown,
  input wire logic link_b_powerdown
);
  logic [7:0] bind_q;
  logic [RDIV_W-1:0] div_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Shadow copies, rebuilt from the write traffic alone
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bind_q <= BINDING_RST;
      div_q <= RDIV_RST;
    end else if (reg_req.wr && reg_req.addr == ADDR_BINDING) begin
      bind_q <= reg_req.wdata[7:0];
    end else if (reg_req.wr && reg_req.addr == ADDR_RDIV) begin
      div_q <= reg_req.wdata;
    end
  end
  sequence s_rd(a);
    reg_req.rd && reg_req.addr == a;
  endsequence
  property p_src_a;
    chan_a_out.data == $past(bind_q[0] ? core_b_in.data : core_a_in.data);
  endproperty
  property p_src_b;
    chan_b_out.data == $past(bind_q[1] ? core_b_in.data : core_a_in.data);
  endproperty
  property p_pd_a;
    chan_a_powerdown == $past(bind_q[0] ? core_b_powerdown : core_a_powerdown);
  endproperty
  property p_pd_b;
    chan_b_powerdown == $past(bind_q[1] ? core_b_powerdown : core_a_powerdown);
  endproperty
  property p_link_a;
    link_a_powerdown == chan_a_powerdown;
  endproperty
  property p_link_b;
    link_b_powerdown == chan_b_powerdown;
  endproperty
  property p_rd_div;
    s_rd(ADDR_RDIV) |=> reg_rdata == div_q;
  endproperty
  property p_rd_bind;
    s_rd(ADDR_BINDING) |=> reg_rdata == {8'h00, bind_q};
  endproperty
  a_src_a: assert property (p_src_a) else $error("chan a source");
  a_src_b: assert property (p_src_b) else $error("chan b source");
  a_pd_a: assert property (p_pd_a) else $error("chan a powerdown");
  a_pd_b: assert property (p_pd_b) else $error("chan b powerdown");
  a_link_a: assert property (p_link_a) else $error("link a");
  a_link_b: assert property (p_link_b) else $error("link b");
  a_rd_div: assert property (p_rd_div) else $error("divisor read");
  a_rd_bind: assert property (p_rd_bind) else $error("bind read");
endmodule
bind dcbnd_top dcbnd_props u_props (.sys_clk(sys_clk), .reset(reset),
  .reg_req(reg_req), .reg_rdata(reg_rdata),
  .core_a_powerdown(core_a_powerdown), .core_b_powerdown(core_b_powerdown),
  .core_a_in(core_a_in), .core_b_in(core_b_in),
  .chan_a_out(chan_a_out), .chan_b_out(chan_b_out),
  .chan_a_powerdown(chan_a_powerdown), .chan_b_powerdown(chan_b_powerdown),
  .link_a_powerdown(link_a_powerdown), .link_b_powerdown(link_b_powerdown));
`default_nettype wire

// ===== test_dcbnd_top.sv
// Self-checking bench for the binding and divisor bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_dcbnd_top
  import dcbnd_pkg::*;
;
  logic sys_clk, reset, pda, pdb, sysref, sreq, mfb;
  logic cpa, cpb, lpa, lpb;
  dcbnd_req_t req;
  dcbnd_sample_t ca, cb, oa, ob;
  logic [DATA_W-1:0] rdata;
  logic [PHASE_W-1:0] fa, fb, pha, phb;
  int fails, compares;
  dcbnd_top dut_u (.sys_clk(sys_clk), .reset(reset), .reg_req(req),
    .reg_rdata(rdata), .core_a_powerdown(pda), .core_b_powerdown(pdb),
    .core_a_in(ca), .core_b_in(cb), .chan_a_out(oa), .chan_b_out(ob),
    .chan_a_powerdown(cpa), .chan_b_powerdown(cpb),
    .link_a_powerdown(lpa), .link_b_powerdown(lpb),
    .freq_word_a(fa), .freq_word_b(fb), .sysref(sysref),
    .sync_request(sreq), .multiframe_boundary(mfb),
    .chan_a_phase(pha), .chan_b_phase(phb));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [15:0] e,
                      input string n);
    @(posedge sys_clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask
  task automatic t_regs;
    rchk(ADDR_BINDING, 16'h0002, "bind");
    rchk(ADDR_RDIV, 16'h0000, "rdiv");
    rchk(ADDR_SYNC, 16'h0002, "sync");
    rchk(12'h218, 16'h0000, "gap");
    $display("test regs done");
  endtask
  task automatic t_route;
    logic [15:0] v;
    for (int b = 0; b < 4; b++) begin
      // Reserved bits set as well: routing must ignore them
      v = {8'h00, 6'h3F, b[1:0]};
      wr(ADDR_BINDING, v);
      cyc(2);
      `CHK("chan a", b[0] ? 12'h222 : 12'h111, oa.data)
      `CHK("chan b", b[1] ? 12'h222 : 12'h111, ob.data)
      rchk(ADDR_BINDING, v, "bind rb");
    end
    $display("test route done");
  endtask
  task automatic t_pd;
    logic [1:0] b;
    logic c;
    // One core down at a time, every binding against each core
    for (int i = 0; i < 8; i++) begin
      b = i[1:0];
      c = i[2];
      pda <= ~c;
      pdb <= c;
      wr(ADDR_BINDING, {14'h0000, b});
      cyc(2);
      `CHK("pd a", b[0] == c, cpa)
      `CHK("pd b", b[1] == c, cpb)
      `CHK("link a", b[0] == c, lpa)
      `CHK("link b", b[1] == c, lpb)
      `CHK("valid a", b[0] != c, oa.valid)
      `CHK("valid b", b[1] != c, ob.valid)
    end
    pda <= 1'b0;
    pdb <= 1'b0;
    wr(ADDR_BINDING, 16'h0002);
    $display("test powerdown done");
  endtask
  task automatic t_nco;
    logic [PHASE_W-1:0] a0, b0;
    int ex;
    // Divisor N adds one extra LSB per N steps, so two steps are exact
    for (int d = 0; d < 3; d++) begin
      wr(ADDR_RDIV, d[15:0]);
      cyc(3);
      a0 = pha;
      b0 = phb;
      cyc(2);
      ex = (d == 0) ? 0 : 2 / d;
      `CHK("step a", a0 + 2 * fa + ex, pha)
      `CHK("step b", b0 + 2 * fb + ex, phb)
      rchk(ADDR_RDIV, d[15:0], "rdiv rb");
    end
    wr(ADDR_RDIV, 16'h0000);
    $display("test divisor done");
  endtask
  task automatic t_sync;
    logic [PHASE_W-1:0] h;
    ca.valid <= 1'b0;
    wr(ADDR_SYNC, 16'h0000);
    wr(ADDR_SYNC, 16'h0001);
    sysref <= 1'b1;
    cyc(2);
    sysref <= 1'b0;
    cyc(3);
    `CHK("armed", 32'h0, pha)
    rchk(ADDR_SYNC, 16'h0001, "sync rb");
    ca.valid <= 1'b1;
    cyc(3);
    ca.valid <= 1'b0;
    cyc(3);
    h = pha;
    sysref <= 1'b1;
    cyc(2);
    sysref <= 1'b0;
    cyc(3);
    `CHK("once", h, pha)
    wr(ADDR_SYNC, 16'h0002);
    sreq <= 1'b1;
    cyc(2);
    mfb <= 1'b1;
    cyc(1);
    mfb <= 1'b0;
    cyc(3);
    `CHK("handshake", 32'h0, pha)
    $display("test sync done");
  endtask
  task automatic summarize;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {reset, pda, pdb, sysref, sreq, mfb} = 6'h20;
    {req, ca, cb} = '0;
    fa = 32'h00000010;
    fb = 32'h00000020;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs;
    ca <= '{1'b1, 12'h111};
    cb <= '{1'b1, 12'h222};
    t_route;
    t_pd;
    t_nco;
    t_sync;
    summarize;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    summarize;
  end
endmodule
`default_nettype wire
